// [rtl/rlep_defines.vh]
// Constants for the program memory lock and verify block
`ifndef RLEP_DEFINES_VH
`define RLEP_DEFINES_VH

// Array geometry
`define RLEP_CODE_AW 16
`define RLEP_CODE_DEPTH 65536
`define RLEP_ENC_AW 6
`define RLEP_ENC_DEPTH 64
`define RLEP_SIG_AW 2
`define RLEP_SIG_DEPTH 4
`define RLEP_ERASED_BYTE 8'hFF

// Programming port modes
`define RLEP_MODE_IDLE 3'h0
`define RLEP_MODE_CODE_WR 3'h1
`define RLEP_MODE_CODE_VF 3'h2
`define RLEP_MODE_ENC_WR 3'h3
`define RLEP_MODE_LOCK_WR 3'h4
`define RLEP_MODE_SIG_RD 3'h5

// Lock byte bit positions in programming data
`define RLEP_LOCK_FIRST_BIT 0
`define RLEP_LOCK_SECOND_BIT 1
`define RLEP_LOCK_THIRD_BIT 2

// Security levels
`define RLEP_LEVEL_1 2'h1
`define RLEP_LEVEL_2 2'h2
`define RLEP_LEVEL_3 2'h3

// Register byte offsets
`define RLEP_OFS_CTRL 4'h0
`define RLEP_OFS_STATUS 4'h4
`define RLEP_OFS_VERIFY 4'h8
`define RLEP_OFS_PULSES 4'hC

// Control register fields and reset value
`define RLEP_CTRL_PORT_EN_BIT 0
`define RLEP_CTRL_CPU_EN_BIT 1
`define RLEP_CTRL_RESET 2'h3

// Status register fields
`define RLEP_ST_LEVEL_LSB 0
`define RLEP_ST_LOCK_LSB 2
`define RLEP_ST_EA_LATCH_BIT 5
`define RLEP_ST_EXT_FETCH_BIT 6

// Cycles after reset release before the fetch select pin is caught
`define RLEP_EA_CATCH_CYCLES 2'h2

`endif

// [rtl/rlep_top.v]
// Program memory arrays, lock levels, encrypted verify and register slave
`timescale 1ns/100ps
`include "rlep_defines.vh"

// Overview of operation
// - Code array 64 KB, encryption array 64 bytes, signature array 4 bytes.
// - Encryption array starts all ones until programmed.
// - Verify uses six address lines to pick an encryption byte.
// - Verify result is code byte XNOR selected encryption byte.
// - Unprogrammed encryption array leaves verify data equal to code.
// - Code byte FFh verifies as its encryption byte.
// - Level 1: no lock, verify still encrypted, external table reads plain.
// - Level 2: external table reads may not fetch internal code bytes.
// - Level 2: fetch select pin latched at reset, later changes ignored.
// - Level 3: like level 1 plus verify disabled; largest variant only.
// - Four factory signature bytes readable in programming mode.
// - Verify data driven only while the port 2.7 enable is asserted.
// - Encryption array has no direct read path.
module rlep_top #(
    parameter [31:0] SIG_WORD = 32'h5A5A_A5A5
) (
    input wire clk_sys,
    input wire rstn,
    // Wishbone classic slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Programming port pins
    input wire [2:0] prog_mode_pin,
    input wire [15:0] prog_addr_pin,
    input wire [7:0] prog_data_in,
    output reg [7:0] prog_data_out,
    output reg prog_data_oe,
    input wire latch_program_strobe_pin_n,
    input wire fetch_select_high_voltage_pin,
    input wire verify_output_enable_n,
    input wire external_fetch_select_pin,
    // Core side code table read
    input wire code_table_read_instr,
    input wire [15:0] table_addr,
    input wire table_from_external,
    output reg [7:0] table_data,
    output reg table_valid,
    output reg table_blocked,
    output reg external_fetch_active
);

    // Nonvolatile arrays
    reg [7:0] code_mem [0:`RLEP_CODE_DEPTH-1];
    reg [7:0] enc_mem [0:`RLEP_ENC_DEPTH-1];
    wire [7:0] sig_byte [0:`RLEP_SIG_DEPTH-1];
    reg lock_bit_first;
    reg lock_bit_second;
    reg lock_bit_third;

    integer i;
    initial begin
        // Erased state of the one-time arrays
        for (i = 0; i < `RLEP_CODE_DEPTH; i = i + 1) begin
            code_mem[i] = `RLEP_ERASED_BYTE;
        end
        for (i = 0; i < `RLEP_ENC_DEPTH; i = i + 1) begin
            enc_mem[i] = `RLEP_ERASED_BYTE;
        end
        lock_bit_first = 1'b1;
        lock_bit_second = 1'b1;
        lock_bit_third = 1'b1;
    end

    // Factory signature bytes, value arbitrary
    genvar g;
    generate
        for (g = 0; g < `RLEP_SIG_DEPTH; g = g + 1) begin : g_sig
            assign sig_byte[g] = SIG_WORD[8*g+7:8*g];
        end
    endgenerate

    // Pin synchronisers
    localparam SW = 31;
    // Idle pin levels, so no false strobe fall or enable follows reset
    localparam [SW-1:0] PIN_IDLE = 31'h0000000A;
    reg [SW-1:0] pin_s1_r;
    reg [SW-1:0] pin_s2_r;
    wire [SW-1:0] pin_raw;
    assign pin_raw = {prog_mode_pin, prog_addr_pin, prog_data_in,
                      latch_program_strobe_pin_n,
                      fetch_select_high_voltage_pin,
                      verify_output_enable_n, external_fetch_select_pin};

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pin_s1_r <= PIN_IDLE;
            pin_s2_r <= PIN_IDLE;
        end else begin
            pin_s1_r <= pin_raw;
            pin_s2_r <= pin_s1_r;
        end
    end

    wire [2:0] mode_s;
    wire [15:0] addr_s;
    wire [7:0] din_s;
    wire strobe_n_s;
    wire hv_s;
    wire oe_n_s;
    wire ea_s;
    assign mode_s = pin_s2_r[30:28];
    assign addr_s = pin_s2_r[27:12];
    assign din_s = pin_s2_r[11:4];
    assign strobe_n_s = pin_s2_r[3];
    assign hv_s = pin_s2_r[2];
    assign oe_n_s = pin_s2_r[1];
    assign ea_s = pin_s2_r[0];

    // Control register
    reg [1:0] ctrl_r;
    wire port_en;
    wire cpu_en;
    assign port_en = ctrl_r[`RLEP_CTRL_PORT_EN_BIT];
    assign cpu_en = ctrl_r[`RLEP_CTRL_CPU_EN_BIT];

    // Security level decode
    reg [1:0] level;
    always @* begin
        if (!lock_bit_first) begin
            level = `RLEP_LEVEL_2;
        end else if (!lock_bit_second) begin
            level = `RLEP_LEVEL_3;
        end else begin
            level = `RLEP_LEVEL_1;
        end
    end
    wire verify_off;
    wire code_table_read_instr_locked;
    assign verify_off = !lock_bit_second;
    assign code_table_read_instr_locked = !lock_bit_first;

    // Fetch select caught once after reset release
    reg [1:0] ea_wait_r;
    reg ea_latched_r;
    reg ea_caught_r;
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ea_wait_r <= 2'h0;
            ea_latched_r <= 1'b0;
            ea_caught_r <= 1'b0;
        end else if (!ea_caught_r) begin
            if (ea_wait_r == `RLEP_EA_CATCH_CYCLES) begin
                ea_latched_r <= ea_s;
                ea_caught_r <= 1'b1;
            end else begin
                ea_wait_r <= ea_wait_r + 2'h1;
            end
        end
    end

    // Level 2 ignores the live pin after the catch
    wire ext_fetch_nxt;
    assign ext_fetch_nxt = code_table_read_instr_locked ? !ea_latched_r : !ea_s;

    // Programming strobe edge
    reg strobe_n_d_r;
    wire strobe_fall;
    assign strobe_fall = strobe_n_d_r & ~strobe_n_s;
    wire prog_pulse;
    assign prog_pulse = port_en & hv_s & strobe_fall;

    // Writes only clear bits, so one pulse fully programs a byte
    always @(posedge clk_sys) begin
        if (prog_pulse && mode_s == `RLEP_MODE_CODE_WR) begin
            code_mem[addr_s] <= code_mem[addr_s] & din_s;
        end
        if (prog_pulse && mode_s == `RLEP_MODE_ENC_WR) begin
            enc_mem[addr_s[5:0]] <= enc_mem[addr_s[5:0]] & din_s;
        end
        if (prog_pulse && mode_s == `RLEP_MODE_LOCK_WR) begin
            lock_bit_first <= lock_bit_first
                              & din_s[`RLEP_LOCK_FIRST_BIT];
            lock_bit_second <= lock_bit_second
                               & din_s[`RLEP_LOCK_SECOND_BIT];
            lock_bit_third <= lock_bit_third
                              & din_s[`RLEP_LOCK_THIRD_BIT];
        end
    end

    // Encrypted verify byte; encryption array itself never reaches a pin
    wire [7:0] code_byte;
    wire [7:0] key_byte;
    wire [7:0] verify_byte;
    assign code_byte = code_mem[addr_s];
    assign key_byte = enc_mem[addr_s[`RLEP_ENC_AW-1:0]];
    assign verify_byte = code_byte ~^ key_byte;

    reg [7:0] dout_nxt;
    reg oe_nxt;
    always @* begin
        dout_nxt = `RLEP_ERASED_BYTE;
        oe_nxt = 1'b0;
        if (port_en && !oe_n_s) begin
            case (mode_s)
                `RLEP_MODE_CODE_VF: begin
                    oe_nxt = 1'b1;
                    if (!verify_off) begin
                        dout_nxt = verify_byte;
                    end
                end
                `RLEP_MODE_SIG_RD: begin
                    oe_nxt = 1'b1;
                    dout_nxt = sig_byte[addr_s[`RLEP_SIG_AW-1:0]];
                end
                default: begin
                    oe_nxt = 1'b0;
                end
            endcase
        end
    end

    reg [7:0] verify_last_r;
    reg [15:0] pulse_cnt_r;
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            prog_data_out <= 8'h00;
            prog_data_oe <= 1'b0;
            strobe_n_d_r <= 1'b1;
            verify_last_r <= 8'h00;
            pulse_cnt_r <= 16'h0000;
            external_fetch_active <= 1'b0;
        end else begin
            prog_data_out <= dout_nxt;
            prog_data_oe <= oe_nxt;
            strobe_n_d_r <= strobe_n_s;
            external_fetch_active <= ext_fetch_nxt;
            if (oe_nxt && mode_s == `RLEP_MODE_CODE_VF) begin
                verify_last_r <= dout_nxt;
            end
            if (prog_pulse) begin
                pulse_cnt_r <= pulse_cnt_r + 16'h0001;
            end
        end
    end

    // Core table reads answer one cycle after the request
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            table_data <= 8'h00;
            table_valid <= 1'b0;
            table_blocked <= 1'b0;
        end else begin
            table_valid <= code_table_read_instr;
            table_blocked <= 1'b0;
            table_data <= 8'h00;
            if (code_table_read_instr) begin
                if (!cpu_en || (code_table_read_instr_locked && table_from_external)) begin
                    table_blocked <= 1'b1;
                    table_data <= `RLEP_ERASED_BYTE;
                end else begin
                    table_data <= code_mem[table_addr];
                end
            end
        end
    end

    // Wishbone classic slave, ack one cycle after the strobe
    wire wb_req;
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    reg [31:0] rd_nxt;
    always @* begin
        rd_nxt = 32'h0000_0000;
        case (wb_adr_i)
            `RLEP_OFS_CTRL: begin
                rd_nxt[1:0] = ctrl_r;
            end
            `RLEP_OFS_STATUS: begin
                rd_nxt[`RLEP_ST_LEVEL_LSB+1:`RLEP_ST_LEVEL_LSB] = level;
                rd_nxt[`RLEP_ST_LOCK_LSB+2:`RLEP_ST_LOCK_LSB] =
                    {lock_bit_third, lock_bit_second, lock_bit_first};
                rd_nxt[`RLEP_ST_EA_LATCH_BIT] = ea_latched_r;
                rd_nxt[`RLEP_ST_EXT_FETCH_BIT] = external_fetch_active;
            end
            `RLEP_OFS_VERIFY: begin
                rd_nxt[7:0] = verify_last_r;
            end
            `RLEP_OFS_PULSES: begin
                rd_nxt[15:0] = pulse_cnt_r;
            end
            default: begin
                rd_nxt = 32'h0000_0000;
            end
        endcase
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            ctrl_r <= `RLEP_CTRL_RESET;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h0000_0000;
            if (wb_req && !wb_we_i) begin
                wb_dat_o <= rd_nxt;
            end
            if (wb_req && wb_we_i && wb_sel_i[0]
                && wb_adr_i == `RLEP_OFS_CTRL) begin
                ctrl_r <= wb_dat_i[1:0];
            end
        end
    end

endmodule

// [verif/rlep_props.sv]
// Checker for the lock and verify block ports
`timescale 1ns/100ps
module rlep_props (
    input wire clk_sys,
    input wire rstn,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire [2:0] prog_mode_pin,
    input wire prog_data_oe,
    input wire verify_output_enable_n,
    input wire code_table_read_instr,
    input wire [7:0] table_data,
    input wire table_valid,
    input wire table_blocked
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence wb_req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence vf_off_s;
        (verify_output_enable_n && prog_mode_pin == 3'h2)[*4];
    endsequence
    ack_next_a: assert property (wb_req_s |=> wb_ack_o) else $error("ack late");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack long");
    ack_cause_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    oe_gate_a: assert property (vf_off_s |-> !prog_data_oe)
        else $error("verify driven while disabled");
    tbl_answer_a: assert property (code_table_read_instr |=>
        (table_valid || table_blocked)) else $error("table read lost");
    tbl_quiet_a: assert property (!code_table_read_instr |=>
        !(table_valid || table_blocked)) else $error("table spurious");
    blk_ones_a: assert property (table_blocked |->
        table_data == 8'hFF) else $error("blocked read leaks data");
endmodule

bind rlep_top rlep_props u_rlep_props (.clk_sys(clk_sys), .rstn(rstn),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .prog_mode_pin(prog_mode_pin),
    .prog_data_oe(prog_data_oe),
    .verify_output_enable_n(verify_output_enable_n),
    .code_table_read_instr(code_table_read_instr), .table_data(table_data),
    .table_valid(table_valid), .table_blocked(table_blocked));

// [verif/rlep_prog_model.sv]
// Programmer model driving the programming and verify pins
`timescale 1ns/100ps
module rlep_prog_model (
    input wire clk_sys,
    output logic [2:0] mode,
    output logic [15:0] addr,
    output logic [7:0] data,
    output logic strobe_n,
    output logic hv,
    output logic oe_n
);
    initial begin
        mode = 3'h0;
        addr = 16'h0;
        data = 8'h0;
        strobe_n = 1'b1;
        hv = 1'b0;
        oe_n = 1'b1;
    end
    task automatic burn(input logic [2:0] m, input logic [15:0] a,
                        input logic [7:0] d);
        mode <= m; addr <= a; data <= d;
        repeat (6) @(posedge clk_sys);
        hv <= 1'b1;
        repeat (6) @(posedge clk_sys);
        strobe_n <= 1'b0;
        repeat (6) @(posedge clk_sys);
        strobe_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        hv <= 1'b0; mode <= 3'h0; data <= ~d;
        repeat (6) @(posedge clk_sys);
    endtask
    task automatic look(input logic [2:0] m, input logic [15:0] a,
                        input logic en);
        mode <= m; addr <= a; oe_n <= !en;
        repeat (8) @(posedge clk_sys);
    endtask
endmodule

// [verif/rlep_top_tb_top.sv]
// Testbench for the lock and verify block
`timescale 1ns/100ps
module rlep_top_tb_top;
    localparam [31:0] SIG = 32'hC3E1_0F96; // Arbitrary signature value
    logic clk_sys = 1'b0, rstn = 1'b0, cyc = 1'b0, we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0, rnd;
    logic ea_pin = 1'b1, treq = 1'b0, text = 1'b0;
    logic [15:0] taddr = 16'h0, a0;
    logic [7:0] c0, e0;
    wire [31:0] rdat;
    wire ack, poe, tvld, tblk, xact, sn, hv, oen;
    wire [7:0] pout, tdat, pdin;
    wire [2:0] pm;
    wire [15:0] pa;
    logic [31:0] wq[$];
    logic [8:0] tq[$];
    int bad_count = 0, tests_run = 0, cyc_n = 0;

    rlep_top #(.SIG_WORD(SIG)) u_rlep_top (.clk_sys(clk_sys), .rstn(rstn),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .prog_mode_pin(pm), .prog_addr_pin(pa), .prog_data_in(pdin),
        .prog_data_out(pout), .prog_data_oe(poe),
        .latch_program_strobe_pin_n(sn), .fetch_select_high_voltage_pin(hv),
        .verify_output_enable_n(oen), .external_fetch_select_pin(ea_pin),
        .code_table_read_instr(treq), .table_addr(taddr),
        .table_from_external(text), .table_data(tdat), .table_valid(tvld),
        .table_blocked(tblk), .external_fetch_active(xact));
    rlep_prog_model u_rlep_prog_model (.clk_sys(clk_sys), .mode(pm),
        .addr(pa), .data(pdin), .strobe_n(sn), .hv(hv), .oe_n(oen));

    initial begin
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task tally_and_finish;
        $display("Counts: tests_run=%0d bad_count=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc_n++;
        if (ack === 1'b1 && !we && wq.size() > 0) chk(rdat, wq.pop_front());
        if ((tvld | tblk) === 1'b1 && tq.size() > 0) begin
            chk({tblk, tdat}, tq.pop_front());
        end
        if (cyc_n == 5000) begin
            bad_count++;
            tally_and_finish;
        end
    end
    // Classic single cycle: hold until ack is sampled, then idle a cycle
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        wq.push_back(e);
        cyc <= 1'b1; adr <= a; we <= 1'b0;
        @(posedge clk_sys iff ack === 1'b1);
        cyc <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        cyc <= 1'b1; adr <= a; we <= 1'b1; wdat <= d;
        @(posedge clk_sys iff ack === 1'b1);
        cyc <= 1'b0; we <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic trd(input logic [15:0] a, input logic x,
                       input logic [8:0] e);
        tq.push_back(e);
        treq <= 1'b1; taddr <= a; text <= x;
        @(posedge clk_sys);
        treq <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic vf(input logic [15:0] a, input logic [7:0] e);
        u_rlep_prog_model.look(3'h2, a, 1'b1);
        chk({poe, pout}, {1'b1, e});
    endtask

    initial begin
        rnd = $urandom(30302);
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (6) @(posedge clk_sys);
        rd(4'h0, 32'h3);
        rd(4'h4, 32'h3D);
        rd(4'h1, 32'h0);
        $display("Test registers done");
        a0 = 16'($urandom);
        c0 = 8'($urandom);
        e0 = 8'($urandom);
        u_rlep_prog_model.burn(3'h1, a0, c0);
        vf(a0, c0);
        vf(a0 ^ 16'h0100, 8'hFF);
        u_rlep_prog_model.burn(3'h3, a0, e0);
        vf(a0, ~(c0 ^ e0));
        vf(a0 ^ 16'h0100, e0);
        u_rlep_prog_model.look(3'h2, a0, 1'b0);
        chk(poe, 1'b0);
        rd(4'hC, 32'h2);
        rd(4'h8, 32'(e0));
        for (int i = 0; i < 4; i++) begin
            u_rlep_prog_model.look(3'h5, 16'(i), 1'b1);
            chk(pout, SIG[8 * i +: 8]);
        end
        $display("Test verify done");
        trd(a0, 1'b1, {1'b0, c0});
        u_rlep_prog_model.burn(3'h4, 16'h0, 8'hFE);
        rd(4'h4, 32'h3A);
        trd(a0, 1'b1, 9'h1FF);
        trd(a0, 1'b0, {1'b0, c0});
        wr(4'h0, 32'h1);
        rd(4'h0, 32'h1);
        trd(a0, 1'b0, 9'h1FF);
        wr(4'h0, 32'h3);
        ea_pin <= 1'b0;
        repeat (6) @(posedge clk_sys);
        chk(xact, 1'b0);
        rstn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (6) @(posedge clk_sys);
        ea_pin <= 1'b1;
        repeat (6) @(posedge clk_sys);
        chk(xact, 1'b1);
        $display("Test lock level two done");
        u_rlep_prog_model.burn(3'h4, 16'h0, 8'hFD);
        vf(a0, 8'hFF);
        rd(4'h8, 32'hFF);
        $display("Test verify disable done");
        repeat (4) @(posedge clk_sys);
        tally_and_finish;
    end
endmodule
